// >>> hdl/dual_port_gpio_d_f.v

`include "gpio_map.vh"

module dual_port_gpio_d_f (
   input  wire        ref_clk,
   input  wire        reset,
   input  wire [4:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire [7:0]  port_d_pin_in,
   output wire [7:0]  port_d_pin_out,
   output wire [7:0]  port_d_pin_oe_n,
   output wire [7:0]  port_d_pullup_on,
   input  wire [7:0]  port_f_pin_in,
   output wire [7:0]  port_f_pin_out,
   output wire [7:0]  port_f_pin_oe_n
);

   localparam [0:0] ST_IDLE = 1'b0;
   localparam [0:0] ST_ACK  = 1'b1;

   reg  [0:0]  state_q;
   reg  [0:0]  state_d;
   reg  [7:0]  port_d_direction_q;
   reg  [7:0]  port_d_output_data_q;
   reg  [7:0]  port_d_pullup_enable_q;
   reg  [7:0]  port_f_direction_q;
   reg  [7:0]  port_f_output_data_q;
   reg  [31:0] read_word_d;
   // write strobes, one per writable register
   reg         wr_d_direction;
   reg         wr_d_output_data;
   reg         wr_d_pullup;
   reg         wr_f_direction;
   reg         wr_f_output_data;
   reg         clk_out_en_q;

   wire [7:0]  port_d_pin_sync;
   wire [7:0]  port_f_pin_sync;
   wire [7:0]  port_d_pin_readback;
   wire [7:0]  port_f_pin_readback;
   wire [7:0]  port_f_out_reg;
   wire        port_f_bit7_direction;
   wire        port_f_bit7_pin;
   wire [7:0]  port_f_out_q_bus;
   wire [7:0]  write_byte;

   wire        request;
   wire        accept;
   wire        read_take;
   wire        write_commit;
   wire        low_lane;
   wire        hit_d_direction;
   wire        hit_d_output_data;
   wire        hit_d_readback;
   wire        hit_d_pullup;
   wire        hit_f_direction;
   wire        hit_f_output_data;
   wire        hit_f_readback;

   // ------------------------------------------------------------------
   // bus slave: every access waits one cycle, then waitrequest drops for
   // exactly one cycle; the master samples it low on the next edge
   // ------------------------------------------------------------------
   assign request    = avs_read | avs_write;
   assign low_lane   = avs_byteenable[`DATA_LANE_BE];
   // only an idle slave takes an access, so the edge that completes one
   // can never start the next while the master still holds it
   assign accept     = request & (state_q == ST_IDLE);
   assign read_take  = avs_read & (state_q == ST_IDLE);
   // registers are 8 bits wide and live in the low byte lane
   assign write_byte = avs_writedata[7:0];

   // a write lands only on the edge where the master sees waitrequest low
   assign write_commit = avs_write & (state_q == ST_ACK) & low_lane;

   assign hit_d_direction   = (avs_address == `PORT_D_DIRECTION_OFS);
   assign hit_d_output_data = (avs_address == `PORT_D_OUTPUT_DATA_OFS);
   assign hit_d_readback    = (avs_address == `PORT_D_READBACK_OFS);
   assign hit_d_pullup      = (avs_address == `PORT_D_PULLUP_OFS);
   assign hit_f_direction   = (avs_address == `PORT_F_DIRECTION_OFS);
   assign hit_f_output_data = (avs_address == `PORT_F_OUTPUT_DATA_OFS);
   assign hit_f_readback    = (avs_address == `PORT_F_READBACK_OFS);

   // one strobe per writable register, raised only on the completing
   // edge; readback and unmapped offsets raise none, so writes there
   // are dropped
   always @* begin
      wr_d_direction   = 1'b0;
      wr_d_output_data = 1'b0;
      wr_d_pullup      = 1'b0;
      wr_f_direction   = 1'b0;
      wr_f_output_data = 1'b0;

      if (write_commit) begin
         case (avs_address)
            `PORT_D_DIRECTION_OFS: begin
               wr_d_direction = 1'b1;
            end
            `PORT_D_OUTPUT_DATA_OFS: begin
               wr_d_output_data = 1'b1;
            end
            `PORT_D_PULLUP_OFS: begin
               wr_d_pullup = 1'b1;
            end
            `PORT_F_DIRECTION_OFS: begin
               wr_f_direction = 1'b1;
            end
            `PORT_F_OUTPUT_DATA_OFS: begin
               wr_f_output_data = 1'b1;
            end
            `PORT_D_READBACK_OFS,
            `PORT_F_READBACK_OFS: begin
               // read-only: the data lands nowhere
               wr_d_direction = 1'b0;
            end
            default: begin
               wr_d_direction = 1'b0;
            end
         endcase
      end
   end

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (request) begin
               state_d = ST_ACK;
            end
         end
         ST_ACK: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // waitrequest is held high while idle, so a new request always stalls
   // one cycle; costs a cycle per access but keeps the output registered
   always @(posedge ref_clk) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
      end else if (accept) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // writable registers
   // ------------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (reset) begin
         port_d_direction_q <= `DIRECTION_RESET;
      end else if (wr_d_direction) begin
         port_d_direction_q <= write_byte;
      end
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         port_d_output_data_q <= `OUTPUT_DATA_RESET;
      end else if (wr_d_output_data) begin
         port_d_output_data_q <= write_byte;
      end
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         port_d_pullup_enable_q <= `PULLUP_RESET;
      end else if (wr_d_pullup) begin
         port_d_pullup_enable_q <= write_byte;
      end
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         port_f_direction_q <= `DIRECTION_RESET;
      end else if (wr_f_direction) begin
         port_f_direction_q <= write_byte;
      end
   end

   // bit 7 is reserved but stored as written; software is expected to
   // keep it zero, and it never reaches a pin
   always @(posedge ref_clk) begin
      if (reset) begin
         port_f_output_data_q <= `OUTPUT_DATA_RESET;
      end else if (wr_f_output_data) begin
         port_f_output_data_q <= write_byte;
      end
   end

   // writes to the readback addresses fall through every branch above,
   // so they change nothing

   // ------------------------------------------------------------------
   // pin inputs cross into ref_clk through two flops
   // ------------------------------------------------------------------
   pin_sync2 u_sync_d (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .pin_async  (port_d_pin_in),
      .pin_sync_q (port_d_pin_sync)
   );

   pin_sync2 u_sync_f (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .pin_async  (port_f_pin_in),
      .pin_sync_q (port_f_pin_sync)
   );

   // ------------------------------------------------------------------
   // readback: output bits reflect the data register, inputs the pin
   // ------------------------------------------------------------------
   genvar i;

   // bit by bit: an output bit shows the data register, an input bit the
   // synchronised pin, which trails the real pin by two edges
   generate
      for (i = 0; i < `PORT_W; i = i + 1) begin : g_readback
         assign port_d_pin_readback[i] = port_d_direction_q[i] ?
            port_d_output_data_q[i] : port_d_pin_sync[i];
         assign port_f_pin_readback[i] = port_f_direction_q[i] ?
            port_f_output_data_q[i] : port_f_pin_sync[i];
      end
   endgenerate

   always @* begin
      read_word_d = `UNDEFINED_READ;
      if (hit_d_output_data) begin
         read_word_d = {24'h000000, port_d_output_data_q};
      end else if (hit_d_readback) begin
         read_word_d = {24'h000000, port_d_pin_readback};
      end else if (hit_d_pullup) begin
         read_word_d = {24'h000000, port_d_pullup_enable_q};
      end else if (hit_f_output_data) begin
         read_word_d = {24'h000000, port_f_output_data_q};
      end else if (hit_f_readback) begin
         read_word_d = {24'h000000, port_f_pin_readback};
      end else if (hit_d_direction || hit_f_direction) begin
         // direction registers are write-only and give no stored bits
         read_word_d = `UNDEFINED_READ;
      end else begin
         // unmapped offsets read the same filler
         read_word_d = `UNDEFINED_READ;
      end
   end

   // read data is captured with waitrequest falling, and stays put
   // until the next access so the master may sample it late
   always @(posedge ref_clk) begin
      if (reset) begin
         avs_readdata <= 32'h0000_0000;
      end else if (read_take) begin
         avs_readdata <= read_word_d;
      end
   end

   // ------------------------------------------------------------------
   // pin drivers
   // ------------------------------------------------------------------
   port_pin_drive u_drive_d (
      .ref_clk       (ref_clk),
      .reset         (reset),
      .direction     (port_d_direction_q),
      .output_data   (port_d_output_data_q),
      .pullup_enable (port_d_pullup_enable_q),
      .pin_out_q     (port_d_pin_out),
      .pin_oe_n_q    (port_d_pin_oe_n),
      .pullup_on_q   (port_d_pullup_on)
   );

   // reserved bit 7 of the data register is kept off the pin: that slot
   // carries the clock instead, so a stray 1 written there is harmless
   // on the pin; it shows when the data register is read, and in the
   // readback while bit 7 is an output
   generate
      for (i = 0; i < `PORT_W; i = i + 1) begin : g_f_data
         if (i == `PORT_F_CLK_BIT) begin : g_clk_slot
            assign port_f_out_reg[i] = 1'b0;
         end else begin : g_data_slot
            assign port_f_out_reg[i] = port_f_output_data_q[i];
         end
      end
   endgenerate

   port_pin_drive u_drive_f (
      .ref_clk       (ref_clk),
      .reset         (reset),
      .direction     (port_f_direction_q),
      .output_data   (port_f_out_reg),
      .pullup_enable (8'h00),
      .pin_out_q     (port_f_out_q_bus),
      .pin_oe_n_q    (port_f_pin_oe_n),
      .pullup_on_q   ()
   );

   assign port_f_bit7_direction = port_f_direction_q[`PORT_F_CLK_BIT];

   // the enable takes one more edge, like oe_n in the pin driver, so the
   // clock reaches the pin in the same cycle that the pin is driven
   always @(posedge ref_clk) begin
      if (reset) begin
         clk_out_en_q <= 1'b0;
      end else begin
         clk_out_en_q <= port_f_bit7_direction;
      end
   end

   // the clock itself cannot come out of a flop, so this output is the
   // one gated path; the enable changes just after a rising edge, so
   // leaving clock mode cuts that last high phase short
   assign port_f_bit7_pin = ref_clk & clk_out_en_q;

   assign port_f_pin_out = {port_f_bit7_pin, port_f_out_q_bus[6:0]};

endmodule // dual_port_gpio_d_f

// >>> hdl/gpio_map.vh
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH

// byte addresses on the register bus, one 32-bit word per register
`define ADDR_W                 5
`define PORT_D_DIRECTION_OFS   5'h00
`define PORT_D_OUTPUT_DATA_OFS 5'h04
`define PORT_D_READBACK_OFS    5'h08
`define PORT_D_PULLUP_OFS      5'h0C
`define PORT_F_DIRECTION_OFS   5'h10
`define PORT_F_OUTPUT_DATA_OFS 5'h14
`define PORT_F_READBACK_OFS    5'h18

// field layout
`define PORT_W                 8
`define PORT_F_CLK_BIT         7
`define DATA_LANE_BE           0

// reset values
`define DIRECTION_RESET        8'h00
`define OUTPUT_DATA_RESET      8'h00
`define PULLUP_RESET           8'h00

// value returned for write-only and unmapped registers
`define UNDEFINED_READ         32'h0000_0000

`endif

// >>> hdl/pin_sync2.v
module pin_sync2 (
   input  wire       ref_clk,
   input  wire       reset,
   input  wire [7:0] pin_async,
   output reg  [7:0] pin_sync_q
);

   reg [7:0] meta_q;

   // first stage is read only by the second stage
   always @(posedge ref_clk) begin
      if (reset) begin
         meta_q     <= 8'h00;
         pin_sync_q <= 8'h00;
      end else begin
         meta_q     <= pin_async;
         pin_sync_q <= meta_q;
      end
   end

endmodule // pin_sync2

// >>> hdl/port_pin_drive.v
module port_pin_drive (
   input  wire       ref_clk,
   input  wire       reset,
   input  wire [7:0] direction,
   input  wire [7:0] output_data,
   input  wire [7:0] pullup_enable,
   output reg  [7:0] pin_out_q,
   output reg  [7:0] pin_oe_n_q,
   output reg  [7:0] pullup_on_q
);

   genvar i;

   generate
      for (i = 0; i < 8; i = i + 1) begin : g_bit
         always @(posedge ref_clk) begin
            if (reset) begin
               pin_out_q[i]   <= 1'b0;
               pin_oe_n_q[i]  <= 1'b1;
               pullup_on_q[i] <= 1'b0;
            end else begin
               pin_out_q[i]   <= output_data[i];
               // enable is active low: driving while direction is 1
               pin_oe_n_q[i]  <= ~direction[i];
               // pull-up only on a pin that is an input
               pullup_on_q[i] <= pullup_enable[i] & ~direction[i];
            end
         end
      end
   endgenerate

endmodule // port_pin_drive

// >>> tb/gpio_properties.sv
`include "gpio_map.vh"
module gpio_properties (
   input wire        ref_clk,
   input wire        reset,
   input wire [4:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire [7:0]  port_d_pin_out,
   input wire [7:0]  port_d_pin_oe_n,
   input wire [7:0]  port_d_pullup_on,
   input wire [7:0]  port_f_pin_out,
   input wire [7:0]  port_f_pin_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_TAKEN:
   assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("request not answered");
   AST_ONE_CYCLE:
   assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   AST_DIR_READ_ZERO:
   assert property (avs_read && avs_waitrequest
      && (avs_address == `PORT_D_DIRECTION_OFS
      || avs_address == `PORT_F_DIRECTION_OFS)
      |=> avs_readdata == `UNDEFINED_READ)
      else $error("direction read not undefined value");
   AST_HIGH_ZERO:
   assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   AST_PULLUP_INPUT:
   assert property ((port_d_pullup_on & ~port_d_pin_oe_n) == 8'h00)
      else $error("pull-up on a driven pin");
   AST_D_PINS_HOLD:
   assert property ($changed({port_d_pin_out, port_d_pin_oe_n,
      port_d_pullup_on}) |-> $past(avs_write && !avs_waitrequest, 2))
      else $error("port d pins moved without a write");
   AST_F_PINS_HOLD:
   assert property ($changed({port_f_pin_out[6:0], port_f_pin_oe_n})
      |-> $past(avs_write && !avs_waitrequest, 2))
      else $error("port f pins moved without a write");
   AST_D_DATA_READ:
   assert property (avs_read && avs_waitrequest
      && avs_address == `PORT_D_OUTPUT_DATA_OFS |=>
      ((avs_readdata[7:0] ^ port_d_pin_out) & ~port_d_pin_oe_n) == 8'h00)
      else $error("data read differs from driven pins");
   // sampled at the falling edge, where the clock output is still high
   AST_F_CLK:
   assert property (@(negedge ref_clk) $fell(port_f_pin_oe_n[7])
      |-> port_f_pin_out[7]) else $error("clock not on pin 7");
endmodule // gpio_properties

// >>> tb/board_pins.sv
module board_pins (
   input  wire [7:0] d_out,
   input  wire [7:0] d_oe_n,
   input  wire [7:0] d_pull,
   input  wire [7:0] f_out,
   input  wire [7:0] f_oe_n,
   input  wire [7:0] d_ext,
   input  wire [7:0] f_ext,
   output wire [7:0] d_pin,
   output wire [7:0] f_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // the external source is weak: a pull-up wins over it
   assign d_pin = (d_out & ~d_oe_n) | (d_oe_n & (d_pull | d_ext));
   assign f_pin = (f_out & ~f_oe_n) | (f_ext & f_oe_n);
endmodule // board_pins

// >>> tb/tb_top.sv
`include "gpio_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [7:0]  d_ext = 8'h5A;
   logic [7:0]  f_ext = 8'h33;
   logic [31:0] q;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest;
   wire  [7:0]  d_in, d_out, d_oe_n, d_pull, f_in, f_out, f_oe_n;
   int          errors = 0;
   int          cmp_count = 0;
   always #10 ref_clk = ~ref_clk;
   dual_port_gpio_d_f DUT (.ref_clk(ref_clk), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .port_d_pin_in(d_in),
      .port_d_pin_out(d_out), .port_d_pin_oe_n(d_oe_n),
      .port_d_pullup_on(d_pull), .port_f_pin_in(f_in),
      .port_f_pin_out(f_out), .port_f_pin_oe_n(f_oe_n));
   board_pins board (.d_out(d_out), .d_oe_n(d_oe_n), .d_pull(d_pull),
      .f_out(f_out), .f_oe_n(f_oe_n), .d_ext(d_ext), .f_ext(f_ext),
      .d_pin(d_in), .f_pin(f_in));
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [7:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      // no cycle count of its own: only the watchdog ends a lost answer
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic rd(input string what, input logic [4:0] a,
                     input logic [31:0] exp);
      bus(1'b0, a, 8'h00, 4'hF);
      chk(what, exp, q);
   endtask
   task automatic settle;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      report_and_stop;
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      rd("d_data", `PORT_D_OUTPUT_DATA_OFS, 32'h0);
      rd("d_pullup", `PORT_D_PULLUP_OFS, 32'h0);
      rd("f_data", `PORT_F_OUTPUT_DATA_OFS, 32'h0);
      $display("test reset_values done");
      wr(`PORT_D_DIRECTION_OFS, 8'hF0);
      wr(`PORT_D_OUTPUT_DATA_OFS, 8'hA5);
      wr(`PORT_D_PULLUP_OFS, 8'h3C);
      settle;
      chk("d_oe_n", 32'h0F, {24'h0, d_oe_n});
      chk("d_out", 32'hA0, {24'h0, d_out & 8'hF0});
      chk("d_pull_on", 32'h0C, {24'h0, d_pull});
      rd("d_back", `PORT_D_READBACK_OFS, 32'hAE);
      rd("d_dir", `PORT_D_DIRECTION_OFS, 32'h0);
      rd("d_pull_back", `PORT_D_PULLUP_OFS, 32'h3C);
      bus(1'b1, `PORT_D_READBACK_OFS, 8'hFF, 4'hF);
      bus(1'b1, `PORT_D_OUTPUT_DATA_OFS, 8'h00, 4'h0);
      bus(1'b1, 5'h1C, 8'hFF, 4'hF);
      rd("d_data_kept", `PORT_D_OUTPUT_DATA_OFS, 32'hA5);
      rd("unmapped", 5'h1C, 32'h0);
      d_ext <= 8'hA5;
      settle;
      rd("d_back_pins", `PORT_D_READBACK_OFS, 32'hAD);
      $display("test port_d done");
      wr(`PORT_F_DIRECTION_OFS, 8'h8F);
      wr(`PORT_F_OUTPUT_DATA_OFS, 8'h7E);
      settle;
      chk("f_oe_n", 32'h70, {24'h0, f_oe_n});
      chk("f_out", 32'h0E, {24'h0, f_out & 8'h0F});
      chk("f_clk_high", 32'h1, {31'h0, f_out[7]});
      @(negedge ref_clk);
      #1;
      chk("f_clk_low", 32'h0, {31'h0, f_out[7]});
      rd("f_back", `PORT_F_READBACK_OFS, 32'h3E);
      rd("f_dir", `PORT_F_DIRECTION_OFS, 32'h0);
      rd("f_data_back", `PORT_F_OUTPUT_DATA_OFS, 32'h7E);
      wr(`PORT_F_DIRECTION_OFS, 8'h00);
      settle;
      chk("f_oe_off", 32'hFF, {24'h0, f_oe_n});
      rd("f_back_pins", `PORT_F_READBACK_OFS, 32'h33);
      $display("test port_f done");
      reset <= 1'b1;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      rd("d_data_rst", `PORT_D_OUTPUT_DATA_OFS, 32'h0);
      settle;
      chk("d_oe_rst", 32'hFF, {24'h0, d_oe_n});
      rd("d_back_rst", `PORT_D_READBACK_OFS, 32'hA5);
      $display("test mid_reset done");
      report_and_stop;
   end
endmodule // tb_top
bind dual_port_gpio_d_f gpio_properties props (.ref_clk(ref_clk),
   .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .port_d_pin_out(port_d_pin_out),
   .port_d_pin_oe_n(port_d_pin_oe_n), .port_d_pullup_on(port_d_pullup_on),
   .port_f_pin_out(port_f_pin_out), .port_f_pin_oe_n(port_f_pin_oe_n));
